/* test/i2cm_eeprom_model.sv */
// Behavioural serial EEPROM slave on open-drain lines
module i2cm_eeprom_model #(parameter logic [6:0] DEV = 7'h50) (
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:15];
    logic [7:0] sh, tx, ptr;
    logic [3:0] b;
    logic [1:0] ph;
    logic on = 1'b0, rd, go, mack;
    initial begin
        sda_oe_o = 1'b0;
        for (int i = 0; i < 16; i++) mem[i] = 8'h50 + 8'(i);
    end
    always @(negedge sda_i) if (scl_i) begin
        on = 1'b1;
        // The clock fall that closes the start is no bit: it wraps the count to zero
        b = 4'hF;
        ph = 2'h0;
        rd = 1'b0;
        go = 1'b0;
        sda_oe_o = 1'b0;
    end
    // stop ends the frame and releases the data line
    always @(posedge sda_i) if (scl_i) begin
        on = 1'b0;
        sda_oe_o = 1'b0;
    end
    // Sample data bits, then the master's acknowledge
    always @(posedge scl_i) if (on) begin
        if (b < 4'h8) sh = {sh[6:0], sda_i};
        else mack = !sda_i;
    end
    // a withheld acknowledge ends sequential output
    always @(negedge scl_i) if (on) begin
        if (b == 4'h7 && !rd) begin
            if (ph == 2'h0) begin
                go = (sh[7:1] == DEV);
                rd = sh[0];
            end else if (ph == 2'h1) ptr = sh;
            else if (go) begin
                mem[ptr[3:0]] = sh;
                ptr = ptr + 8'h01;
            end
            if (ph != 2'h2) ph = ph + 2'h1;
            sda_oe_o = go;
        end else if (b == 4'h8) begin
            sda_oe_o = 1'b0;
            if (rd) go = go && mack;
            if (rd && go) begin
                tx = mem[ptr[3:0]];
                ptr = ptr + 8'h01;
                sda_oe_o = !tx[7];
            end
        end else if (b == 4'h7) sda_oe_o = 1'b0;
        else if (rd && go) sda_oe_o = !tx[3'(6 - b)];
        b = (b == 4'h8) ? 4'h0 : b + 4'h1;
    end
endmodule

/* test/i2cm_master_chk_sva.sv */
// Assertion checker for the I2C master controller ports
module i2cm_master_chk (
    input logic ref_clk_i,
    input logic rstn_i,
    input logic tx_wr_i,
    input logic rx_rd_i,
    input logic rx_byte_ready_flag_o,
    input logic transfer_done_flag_o,
    input logic slave_ack_seen_flag_o,
    input logic bus_owned_o,
    input logic scl_oe_o,
    input logic sda_oe_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    // Status flags, line timing and receive buffer relations
    a_done_clear: assert property (
        tx_wr_i && transfer_done_flag_o |-> ##[1:2] !transfer_done_flag_o)
        else $error("done flag not cleared by data write");
    a_done_holds: assert property (
        transfer_done_flag_o && !tx_wr_i |=> transfer_done_flag_o)
        else $error("done flag dropped without a data write");
    a_ack_update: assert property (
        !$rose(transfer_done_flag_o) |-> $stable(slave_ack_seen_flag_o))
        else $error("ack flag moved outside byte completion");
    a_start_owns: assert property (
        $rose(sda_oe_o) && !scl_oe_o |-> ##[1:30] (bus_owned_o && scl_oe_o))
        else $error("start not followed by owned bus");
    a_stop_frees: assert property (
        $fell(sda_oe_o) && !scl_oe_o |-> ##[1:30] !bus_owned_o)
        else $error("stop did not release the bus");
    a_idle_lines: assert property (
        transfer_done_flag_o && !bus_owned_o |-> !sda_oe_o && !scl_oe_o)
        else $error("lines held while bus not owned");
    a_scl_high: assert property (
        $fell(scl_oe_o) && bus_owned_o |-> ##[49:51] (scl_oe_o || !bus_owned_o))
        else $error("serial clock high phase length wrong");
    a_rx_after: assert property (
        $rose(rx_byte_ready_flag_o) |-> transfer_done_flag_o)
        else $error("received byte flagged before completion");
    a_rx_keeps: assert property (
        rx_byte_ready_flag_o && !rx_rd_i |=> rx_byte_ready_flag_o)
        else $error("received byte lost without a pop");
endmodule
bind i2cm_master i2cm_master_chk u_chk (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
    .tx_wr_i(tx_wr_i), .rx_rd_i(rx_rd_i), .rx_byte_ready_flag_o(rx_byte_ready_flag_o),
    .transfer_done_flag_o(transfer_done_flag_o), .bus_owned_o(bus_owned_o),
    .slave_ack_seen_flag_o(slave_ack_seen_flag_o), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o));

/* test/tb.sv */
// Testbench for the I2C master controller against an EEPROM model
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 1'b0, rstn_i = 1'b0, ctrl_wr = 1'b0, tx_wr = 1'b0, rx_rd = 1'b0;
    logic st = 1'b0, sp = 1'b0, ak = 1'b0, en = 1'b0;
    logic [7:0] tx_d = 8'h00, rx_d;
    logic rx_rdy, done, ack, own, scl_o, scl_oe, sda_o, sda_oe, s_oe;
    wire scl, sda;
    int err_total = 0, total_checks = 0;
    logic [7:0] pw [3] = '{8'h04, 8'hA5, 8'h3C};
    always #50 ref_clk_i = !ref_clk_i;
    // Open-drain lines with pull-ups
    assign scl = scl_oe ? scl_o : 1'b1;
    assign sda = (sda_oe ? sda_o : 1'b1) & !s_oe;
    i2cm_master uut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ctrl_wr_i(ctrl_wr),
        .begin_condition_request_i(st), .end_condition_request_i(sp),
        .master_ack_drive_bit_i(ak), .controller_enable_bit_i(en), .tx_wr_i(tx_wr),
        .tx_data_i(tx_d), .rx_rd_i(rx_rd), .rx_data_o(rx_d), .rx_byte_ready_flag_o(rx_rdy),
        .transfer_done_flag_o(done), .slave_ack_seen_flag_o(ack), .bus_owned_o(own),
        .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe_o(sda_oe));
    i2cm_eeprom_model slv (.scl_i(scl), .sda_i(sda), .sda_oe_o(s_oe));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Control write: start, stop, ack-out, enable
    task automatic ctl(input logic [3:0] v);
        @(negedge ref_clk_i);
        {st, sp, ak, en} = v;
        ctrl_wr = 1'b1;
        @(negedge ref_clk_i);
        ctrl_wr = 1'b0;
    endtask
    // Data write, then poll for completion under a bound
    task automatic op(input logic [7:0] d);
        int n;
        n = 0;
        @(negedge ref_clk_i);
        chk(done, 8'h01);
        tx_d = d;
        tx_wr = 1'b1;
        @(negedge ref_clk_i);
        tx_wr = 1'b0;
        @(negedge ref_clk_i);
        chk(done, 8'h00);
        // give up after about one millisecond
        while (done !== 1'b1 && n < 10000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n == 10000) chk(8'h00, 8'h01);
    endtask
    // Pop one received byte after it has landed
    task automatic pop(input logic [7:0] e);
        repeat (3) @(negedge ref_clk_i);
        chk(rx_rdy, 8'h01);
        chk(rx_d, e);
        rx_rd = 1'b1;
        @(negedge ref_clk_i);
        rx_rd = 1'b0;
    endtask
    // Stop with a dummy byte, bus must be free afterwards
    task automatic stop;
        ctl(4'h5);
        op(8'h00);
        chk({own, scl_oe, sda_oe, rx_rdy, scl_o, sda_o}, 8'h00);
    endtask
    initial begin
        repeat (2) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        chk({done, ack, own, rx_rdy}, 8'h08);
        // Disabled write completes at once with no bus activity
        ctl(4'h0);
        @(negedge ref_clk_i);
        tx_wr = 1'b1;
        @(negedge ref_clk_i);
        tx_wr = 1'b0;
        chk({done, scl_oe, sda_oe}, 8'h00);
        repeat (2) @(negedge ref_clk_i);
        chk({done, own, scl_oe, sda_oe}, 8'h08);
        // address, word address and two data words
        ctl(4'h9);
        op(8'hA0);
        chk({ack, own}, 8'h03);
        ctl(4'h1);
        foreach (pw[i]) begin
            op(pw[i]);
            chk(ack, 8'h01);
        end
        stop();
        chk(slv.mem[4], 8'hA5);
        chk(slv.mem[5], 8'h3C);
        // Absent device answers with no acknowledge
        ctl(4'h9);
        op(8'hB0);
        chk(ack, 8'h00);
        stop();
        // sequential read with a repeated start
        ctl(4'h9);
        op(8'hA0);
        ctl(4'h1);
        op(8'h04);
        chk(ack, 8'h01);
        ctl(4'hB);
        op(8'hA1);
        chk(ack, 8'h01);
        ctl(4'h3);
        op(8'h00);
        op(8'h00);
        pop(8'hA5);
        pop(8'h3C);
        ctl(4'h1);
        op(8'h00);
        pop(8'h56);
        chk(slv.go, 8'h00);
        stop();
        tally_and_finish();
    end
    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge ref_clk_i);
        err_total++;
        tally_and_finish();
    end
endmodule

/* verilog/i2cm_buf2.v */
// Two-entry buffer with valid and ready on both sides
module i2cm_buf2 (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [7:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [7:0] out_data_o
);
    reg [7:0] mem_q [0:1];
    reg [1:0] used_q;
    wire push;
    wire pop;

    // Entry 0 is the head, entry 1 the tail
    assign in_ready_o = ~used_q[1];
    assign out_valid_o = used_q[0];
    assign out_data_o = mem_q[0];
    assign push = in_valid_i & ~used_q[1];
    assign pop = used_q[0] & out_ready_i;

    // Shift the tail forward on a pop; a push fills the first free entry
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mem_q[0] <= 8'h00;
            mem_q[1] <= 8'h00;
            used_q <= 2'b00;
        end else if (pop) begin
            if (used_q[1]) begin
                mem_q[0] <= mem_q[1];
                used_q <= 2'b01;
            end else if (push) begin
                mem_q[0] <= in_data_i;
            end else begin
                used_q <= 2'b00;
            end
        end else if (push) begin
            if (!used_q[0]) begin
                mem_q[0] <= in_data_i;
                used_q <= 2'b01;
            end else begin
                mem_q[1] <= in_data_i;
                used_q <= 2'b11;
            end
        end
    end
endmodule

/* verilog/i2cm_master.v */
// Register-driven I2C master controller for page write and sequential read
`include "i2cm_regs.vh"
module i2cm_master (
    input wire ref_clk_i,
    input wire rstn_i,
    input wire ctrl_wr_i,
    input wire begin_condition_request_i,
    input wire end_condition_request_i,
    input wire master_ack_drive_bit_i,
    input wire controller_enable_bit_i,
    input wire tx_wr_i,
    input wire [7:0] tx_data_i,
    input wire rx_rd_i,
    output wire [7:0] rx_data_o,
    output wire rx_byte_ready_flag_o,
    output reg transfer_done_flag_o,
    output reg slave_ack_seen_flag_o,
    output reg bus_owned_o,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe_o,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o
);
    localparam [4:0] S_IDLE = 5'b00001;
    localparam [4:0] S_WAIT = 5'b00010;
    localparam [4:0] S_START = 5'b00100;
    localparam [4:0] S_BITS = 5'b01000;
    localparam [4:0] S_STOP = 5'b10000;

    reg [4:0] state_q;
    reg [4:0] qcnt_q;
    reg [1:0] ph_q;
    reg [3:0] bit_q;
    reg [8:0] sh_q;
    reg [8:0] rx_q;
    reg addr_q;
    reg rd_op_q;
    reg rd_mode_q;
    reg start_q;
    reg stop_q;
    reg ackout_q;
    reg enable_q;
    reg scl_m_q;
    reg scl_s_q;
    reg sda_m_q;
    reg sda_s_q;
    reg push_q;
    reg [7:0] push_data_q;
    wire buf_ready;
    wire step;
    wire hold;

    // Frame for a byte: eight bits then the acknowledge slot
    function [8:0] frame;
        input [7:0] data;
        input ack_low;
        begin
            frame = {data, ~ack_low};
        end
    endfunction

    // Received bytes wait here so a slow reader loses none
    i2cm_buf2 u_rxbuf (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .in_valid_i(push_q),
        .in_ready_o(buf_ready),
        .in_data_i(push_data_q),
        .out_valid_o(rx_byte_ready_flag_o),
        .out_ready_i(rx_rd_i),
        .out_data_o(rx_data_o)
    );

    // Two-flop synchronisers for the bus lines
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            scl_m_q <= 1'b1;
            scl_s_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_s_q <= 1'b1;
        end else begin
            scl_m_q <= scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // Control register bits, loaded on a control write
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            start_q <= 1'b0;
            stop_q <= 1'b0;
            ackout_q <= 1'b0;
            enable_q <= 1'b0;
        end else if (ctrl_wr_i) begin
            start_q <= begin_condition_request_i;
            stop_q <= end_condition_request_i;
            ackout_q <= master_ack_drive_bit_i;
            enable_q <= controller_enable_bit_i;
        end
    end

    // A quarter ends when its count runs out; a stretched clock holds phase 2
    assign hold = (ph_q == 2'd2) && !scl_s_q;
    assign step = (qcnt_q == 5'd0) && !hold;

    // Command decode, bit engine and status flags
    always @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= S_IDLE;
            qcnt_q <= 5'd0;
            ph_q <= 2'd0;
            bit_q <= 4'h0;
            sh_q <= 9'h1FF;
            rx_q <= 9'h000;
            addr_q <= 1'b0;
            rd_op_q <= 1'b0;
            rd_mode_q <= 1'b0;
            push_q <= 1'b0;
            push_data_q <= 8'h00;
            transfer_done_flag_o <= `I2CM_DONE_RST;
            slave_ack_seen_flag_o <= `I2CM_ACK_RST;
            bus_owned_o <= 1'b0;
            scl_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            push_q <= 1'b0;
            if (state_q != S_IDLE && state_q != S_WAIT) begin
                if (qcnt_q != 5'd0) begin
                    qcnt_q <= qcnt_q - 5'd1;
                end else if (step) begin
                    qcnt_q <= `I2CM_QTR_LOAD;
                    ph_q <= ph_q + 2'd1;
                end
            end
            case (state_q)
                S_IDLE: begin
                    if (tx_wr_i) begin
                        transfer_done_flag_o <= 1'b0;
                        ph_q <= 2'd0;
                        qcnt_q <= `I2CM_QTR_LOAD;
                        bit_q <= 4'h0;
                        addr_q <= start_q;
                        rd_op_q <= 1'b0;
                        if (!enable_q) begin
                            state_q <= S_WAIT;
                        end else if (start_q) begin
                            sh_q <= frame(tx_data_i, 1'b0);
                            state_q <= S_START;
                        end else if (stop_q) begin
                            state_q <= S_STOP;
                        end else if (rd_mode_q) begin
                            rd_op_q <= 1'b1;
                            sh_q <= frame(8'hFF, ackout_q);
                            state_q <= S_WAIT;
                        end else begin
                            sh_q <= frame(tx_data_i, 1'b0);
                            state_q <= S_BITS;
                        end
                    end
                end
                S_WAIT: begin
                    // Disabled writes finish at once; reads wait for buffer room
                    if (!enable_q) begin
                        transfer_done_flag_o <= 1'b1;
                        state_q <= S_IDLE;
                    end else if (buf_ready) begin
                        qcnt_q <= `I2CM_QTR_LOAD;
                        state_q <= S_BITS;
                    end
                end
                S_START: begin
                    if (step) begin
                        case (ph_q)
                            2'd0: sda_oe_o <= 1'b0;
                            2'd1: scl_oe_o <= 1'b0;
                            2'd2: sda_oe_o <= 1'b1;
                            default: begin
                                scl_oe_o <= 1'b1;
                                bus_owned_o <= 1'b1;
                                state_q <= S_BITS;
                            end
                        endcase
                    end
                end
                S_BITS: begin
                    if (step) begin
                        case (ph_q)
                            2'd0: sda_oe_o <= ~sh_q[8];
                            2'd1: scl_oe_o <= 1'b0;
                            2'd2: rx_q <= {rx_q[7:0], sda_s_q};
                            default: begin
                                scl_oe_o <= 1'b1;
                                sh_q <= {sh_q[7:0], 1'b1};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == `I2CM_FRAME_LAST) begin
                                    // Data line kept as the ack slot left it; next phase 0 moves it
                                    transfer_done_flag_o <= 1'b1;
                                    state_q <= S_IDLE;
                                    if (rd_op_q) begin
                                        push_q <= 1'b1;
                                        push_data_q <= rx_q[8:1];
                                    end else begin
                                        slave_ack_seen_flag_o <= ~rx_q[0];
                                        if (addr_q) begin
                                            rd_mode_q <= rx_q[`I2CM_DIR_BIT + 1];
                                        end
                                    end
                                end
                            end
                        endcase
                    end
                end
                S_STOP: begin
                    if (step) begin
                        case (ph_q)
                            2'd0: sda_oe_o <= 1'b1;
                            2'd1: scl_oe_o <= 1'b0;
                            2'd2: sda_oe_o <= 1'b0;
                            default: begin
                                bus_owned_o <= 1'b0;
                                rd_mode_q <= 1'b0;
                                transfer_done_flag_o <= 1'b1;
                                state_q <= S_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end
endmodule

/* verilog/i2cm_regs.vh */
// Constants for the multibyte I2C master controller
`ifndef I2CM_REGS_VH
`define I2CM_REGS_VH

// System clock period in ns (10 MHz)
`define I2CM_CLK_PERIOD_NS 100
// Serial clock period in ns (100 kHz standard mode)
`define I2CM_SCL_PERIOD_NS 10000
// Cycles per quarter of a serial bit, derived from the two periods
`define I2CM_QTR_CYC (`I2CM_SCL_PERIOD_NS / (4 * `I2CM_CLK_PERIOD_NS))
// Reload value of the quarter counter
`define I2CM_QTR_LOAD 5'd24
// Index of the last bit in a frame: eight data bits then the acknowledge bit
`define I2CM_FRAME_LAST 4'h8
// Bit 0 of an address byte: read direction when set
`define I2CM_DIR_BIT 0
// Reset values of the status flags
`define I2CM_DONE_RST 1'b1
`define I2CM_ACK_RST 1'b0
// Software abort wait, in us (kept by software only)
`define I2CM_ABORT_WAIT_US 1000

`endif
